// *** shared/acsr_pkg.sv ***
// Constants for the accelerometer status and output register bank.
// Assumes a byte-wide register port fed by an external serial slave.
package acsr_pkg;
  // Register offsets
  localparam logic [7:0] OFS_SRC0   = 8'h00;
  localparam logic [7:0] OFS_SRC1   = 8'h01;
  localparam logic [7:0] OFS_STATUS = 8'h02;
  localparam logic [7:0] OFS_X_HI   = 8'h03;
  localparam logic [7:0] OFS_X_LO   = 8'h04;
  localparam logic [7:0] OFS_Y_HI   = 8'h05;
  localparam logic [7:0] OFS_Y_LO   = 8'h06;
  localparam logic [7:0] OFS_Z_HI   = 8'h07;
  localparam logic [7:0] OFS_Z_LO   = 8'h08;
  localparam logic [7:0] OFS_TEMP   = 8'h09;
  localparam logic [7:0] OFS_MASK0  = 8'h0a;
  localparam logic [7:0] OFS_MASK1  = 8'h0b;
  // Field positions
  localparam int         BIT_SOFT_RESET = 7;
  localparam int         BIT_READY      = 0;
  localparam int         BIT_CAL        = 4;
  localparam logic [7:0] SRC0_BITS      = 8'hcf;
  // Plane orientation codes
  localparam logic [1:0] XY_POS_X = 2'h0;
  localparam logic [1:0] XY_POS_Y = 2'h1;
  localparam logic [1:0] XY_NEG_X = 2'h2;
  localparam logic [1:0] XY_NEG_Y = 2'h3;
  // Debounce base count for code 00, doubled per code step
  localparam logic [7:0] DEBOUNCE_BASE = 8'h10;
  // 0.375g at 1024 counts per g
  localparam logic [11:0] TILT_THRESH_2G = 12'h180;
  // Reset values
  localparam logic [7:0] RST_BYTE   = 8'h00;
  localparam logic [1:0] RST_ORIENT = 2'h0;
  localparam logic [7:0] RST_COUNT  = 8'h00;
endpackage

// *** src/acsr_regs.sv ***
// Status, orientation and output register bank of the accelerometer.
// Assumes the serial slave delivers byte reads and writes on a simple port
// and raises xfer_active_i for the whole of each transfer.
`timescale 1ns/1ns
`default_nettype none
module acsr_regs
  import acsr_pkg::*;
#(
  parameter logic [11:0] TILT_THRESH = TILT_THRESH_2G
) (
  // Clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        rst_i,
  // Register port from the serial slave
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  input  wire logic [7:0]  reg_wdata_i,
  input  wire logic        xfer_active_i,
  output logic      [7:0]  reg_rdata_o,
  // Measurement path
  input  wire logic        meas_valid_i,
  input  wire logic [11:0] x_accel_i,
  input  wire logic [11:0] y_accel_i,
  input  wire logic [11:0] z_accel_i,
  input  wire logic [7:0]  temperature_value_i,
  input  wire logic        otp_done_i,
  input  wire logic [3:0]  shake_evt_i,
  input  wire logic [1:0]  orientation_debounce_count_i,
  // Outputs to pin and rest of device
  output logic             irq_pin_o,
  output logic             irq_pin_oe_n_o,
  output logic             soft_reset_o
);
  // Control state
  logic        srst_q, srst_d;
  logic        dev_rst;
  logic [7:0]  rdata_q, rdata_d;
  logic        irq_n_q, irq_n_d;
  logic [7:0]  src0_q, src0_d;
  logic        ready_q, ready_d;
  logic        cal_q, cal_d;
  logic [7:0]  mask0_q, mask0_d;
  logic        mask1_q, mask1_d;
  // Sample state
  logic        pend_q, pend_d;
  logic [11:0] px_q, px_d, py_q, py_d, pz_q, pz_d;
  logic [7:0]  pt_q, pt_d;
  logic [11:0] xo_q, xo_d, yo_q, yo_d, zo_q, zo_d;
  logic [7:0]  to_q, to_d;
  logic        take;
  logic [11:0] s_x, s_y, s_z;
  logic [7:0]  s_t;
  // Orientation state
  logic [1:0]  ixy_q, ixy_d, iz_q, iz_d;
  logic [1:0]  fxy_q, fxy_d, fz_q, fz_d;
  logic [3:0]  cand_q, cand_d;
  logic [7:0]  cnt_q, cnt_d;
  logic [7:0]  target;
  logic [11:0] ax, ay, big;
  logic        plane_ok;
  logic [1:0]  new_xy, new_z;
  logic        orient_upd;
  // Write decode
  logic        wr_src0, wr_src1;

  // Soft reset covers everything except the register port and itself
  assign dev_rst = rst_i | srst_q;
  assign wr_src0 = reg_wr_i & (reg_addr_i == OFS_SRC0);
  assign wr_src1 = reg_wr_i & (reg_addr_i == OFS_SRC1);

  // Soft reset request, held for the rest of the carrying transfer
  always_comb begin
    srst_d = srst_q;
    if (wr_src1 && reg_wdata_i[BIT_SOFT_RESET]) begin
      srst_d = 1'b1;
    end else if (!xfer_active_i) begin
      srst_d = 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      srst_q <= 1'b0;
    end else begin
      srst_q <= srst_d;
    end
  end

  // Sample parking: a sample arriving mid-transfer waits for its end,
  // so a burst read of high and low bytes never straddles two samples
  always_comb begin
    pend_d = pend_q;
    px_d   = px_q;
    py_d   = py_q;
    pz_d   = pz_q;
    pt_d   = pt_q;
    xo_d   = xo_q;
    yo_d   = yo_q;
    zo_d   = zo_q;
    to_d   = to_q;
    if (meas_valid_i) begin
      px_d = x_accel_i;
      py_d = y_accel_i;
      pz_d = z_accel_i;
      pt_d = temperature_value_i;
    end
    take   = !xfer_active_i && (meas_valid_i || pend_q);
    s_x    = meas_valid_i ? x_accel_i : px_q;
    s_y    = meas_valid_i ? y_accel_i : py_q;
    s_z    = meas_valid_i ? z_accel_i : pz_q;
    s_t    = meas_valid_i ? temperature_value_i : pt_q;
    pend_d = xfer_active_i && (pend_q || meas_valid_i);
    if (take) begin
      xo_d = s_x;
      yo_d = s_y;
      zo_d = s_z;
      to_d = s_t;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (dev_rst) begin
      pend_q <= 1'b0;
      px_q   <= 12'h000;
      py_q   <= 12'h000;
      pz_q   <= 12'h000;
      pt_q   <= RST_BYTE;
      xo_q   <= 12'h000;
      yo_q   <= 12'h000;
      zo_q   <= 12'h000;
      to_q   <= RST_BYTE;
    end else begin
      pend_q <= pend_d;
      px_q   <= px_d;
      py_q   <= py_d;
      pz_q   <= pz_d;
      pt_q   <= pt_d;
      xo_q   <= xo_d;
      yo_q   <= yo_d;
      zo_q   <= zo_d;
      to_q   <= to_d;
    end
  end

  // Orientation: instant decode and consecutive-reading debounce.
  // One reading per published sample; the sample rate sets the time base.
  always_comb begin
    ax       = s_x[11] ? 12'(-s_x) : s_x; // -2048 gives 0x800, still right unsigned
    ay       = s_y[11] ? 12'(-s_y) : s_y;
    big      = (ax >= ay) ? ax : ay;
    plane_ok = big > TILT_THRESH;
    if (!plane_ok) begin
      new_xy = ixy_q;
    end else if (ax >= ay) begin
      new_xy = s_x[11] ? XY_NEG_X : XY_POS_X;
    end else begin
      new_xy = s_y[11] ? XY_NEG_Y : XY_POS_Y;
    end
    new_z      = {~plane_ok, s_z[11]};
    target     = 8'(DEBOUNCE_BASE << orientation_debounce_count_i);
    ixy_d      = ixy_q;
    iz_d       = iz_q;
    fxy_d      = fxy_q;
    fz_d       = fz_q;
    cand_d     = cand_q;
    cnt_d      = cnt_q;
    orient_upd = 1'b0;
    if (take) begin
      ixy_d = new_xy;
      iz_d  = new_z;
      if ({new_z, new_xy} == {fz_q, fxy_q}) begin
        cnt_d  = RST_COUNT;
        cand_d = {new_z, new_xy};
      end else if ({new_z, new_xy} == cand_q) begin
        cnt_d = 8'(cnt_q + 8'h01);
        if (cnt_d >= target) begin
          orient_upd = 1'b1;
          cnt_d      = RST_COUNT;
          fz_d       = new_z;
          fxy_d      = new_z[1] ? fxy_q : new_xy;
        end
      end else begin
        cand_d = {new_z, new_xy};
        cnt_d  = 8'h01;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (dev_rst) begin
      ixy_q  <= RST_ORIENT;
      iz_q   <= RST_ORIENT;
      fxy_q  <= RST_ORIENT;
      fz_q   <= RST_ORIENT;
      cand_q <= {RST_ORIENT, RST_ORIENT};
      cnt_q  <= RST_COUNT;
    end else begin
      ixy_q  <= ixy_d;
      iz_q   <= iz_d;
      fxy_q  <= fxy_d;
      fz_q   <= fz_d;
      cand_q <= cand_d;
      cnt_q  <= cnt_d;
    end
  end

  // Sources, masks, calibration flag and interrupt pin.
  // Clear strobes are never stored, so they self-clear after one write.
  always_comb begin
    src0_d = src0_q & ~(wr_src0 ? (reg_wdata_i & SRC0_BITS) : RST_BYTE);
    src0_d = src0_d | {orient_upd && (fz_d != fz_q),
                       orient_upd && (fxy_d != fxy_q), 2'h0, shake_evt_i};
    ready_d = (ready_q && !(wr_src1 && reg_wdata_i[BIT_READY])) || take;
    cal_d   = cal_q || otp_done_i;
    mask0_d = mask0_q;
    mask1_d = mask1_q;
    if (reg_wr_i && reg_addr_i == OFS_MASK0) begin
      mask0_d = reg_wdata_i & SRC0_BITS;
    end
    if (reg_wr_i && reg_addr_i == OFS_MASK1) begin
      mask1_d = reg_wdata_i[BIT_READY];
    end
    irq_n_d = !((|(src0_q & mask0_q)) || (ready_q && mask1_q));
  end

  always_ff @(posedge sys_clk_i) begin
    if (dev_rst) begin
      src0_q  <= RST_BYTE;
      ready_q <= 1'b0;
      cal_q   <= 1'b0;
      mask0_q <= RST_BYTE;
      mask1_q <= 1'b0;
      irq_n_q <= 1'b1;
    end else begin
      src0_q  <= src0_d;
      ready_q <= ready_d;
      cal_q   <= cal_d;
      mask0_q <= mask0_d;
      mask1_q <= mask1_d;
      irq_n_q <= irq_n_d;
    end
  end

  // Read data, registered one cycle after the strobe; masks read as zero
  always_comb begin
    rdata_d = rdata_q;
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        OFS_SRC0:   rdata_d = src0_q;
        OFS_SRC1:   rdata_d = {fz_q, fxy_q, 3'h0, ready_q};
        OFS_STATUS: rdata_d = {3'h0, cal_q, iz_q, ixy_q};
        OFS_X_HI:   rdata_d = xo_q[11:4];
        OFS_X_LO:   rdata_d = {xo_q[3:0], 4'h0};
        OFS_Y_HI:   rdata_d = yo_q[11:4];
        OFS_Y_LO:   rdata_d = {yo_q[3:0], 4'h0};
        OFS_Z_HI:   rdata_d = zo_q[11:4];
        OFS_Z_LO:   rdata_d = {zo_q[3:0], 4'h0};
        OFS_TEMP:   rdata_d = to_q;
        default:    rdata_d = RST_BYTE;
      endcase
    end
  end

  // Read path stays alive through soft reset so the transfer completes
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      rdata_q <= RST_BYTE;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata_o    = rdata_q;
  assign irq_pin_o      = 1'b0; // Open drain only ever pulls low
  assign irq_pin_oe_n_o = irq_n_q; // Flop holds the active-low level, no gate after it
  assign soft_reset_o   = srst_q;

  // Checks
  sequence s_srst_req;
    wr_src1 && reg_wdata_i[BIT_SOFT_RESET];
  endsequence
  sequence s_srst_held;
    srst_q && xfer_active_i;
  endsequence

  a_srst_taken: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    s_srst_req |=> srst_q && soft_reset_o) else $error("soft reset not taken");
  a_srst_hold: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    s_srst_held |=> srst_q) else $error("soft reset dropped mid transfer");
  a_srst_release: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    srst_q && !xfer_active_i && !reg_wr_i |=> !srst_q) else $error("soft reset stuck");
  a_cal_sticky: assert property (@(posedge sys_clk_i) disable iff (dev_rst)
    cal_q |=> cal_q) else $error("calibration flag cleared");
  a_ready_set: assert property (@(posedge sys_clk_i) disable iff (dev_rst)
    take |=> ready_q ##1 (ready_q || $past(wr_src1))) else $error("ready flag missed");
  a_low_nibble: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    reg_rd_i && reg_addr_i == OFS_X_LO |=> reg_rdata_o[3:0] == 4'h0 && reg_rdata_o[7:4] == $past(xo_q[3:0]))
    else $error("low byte format wrong");
  a_irq_nor: assert property (@(posedge sys_clk_i) disable iff (dev_rst)
    ((|(src0_q & mask0_q)) || (ready_q && mask1_q)) |=> !irq_pin_oe_n_o) else $error("interrupt not driven");
  a_plane_frozen: assert property (@(posedge sys_clk_i) disable iff (dev_rst)
    fz_q[1] && !$past(dev_rst) |-> $stable(fxy_q)) else $error("plane moved while tilted");
  a_filter_count: assert property (@(posedge sys_clk_i) disable iff (dev_rst)
    !$past(dev_rst) && !$stable({fz_q, fxy_q}) |-> $past(cnt_q) == 8'($past(target) - 8'h01))
    else $error("filter changed early");
  a_set_wins: assert property (@(posedge sys_clk_i) disable iff (dev_rst)
    shake_evt_i[0] |=> src0_q[0]) else $error("shake event lost");
endmodule
`default_nettype wire

// *** sim/acsr_host_model.sv ***
// Serial bus master model driving the bank's register port.
// Assumes one clock; requests change on its falling edge only.
`timescale 1ns/1ns
`default_nettype none
module acsr_host_model (
  // Clock
  input  wire logic       clk_i,
  // Register port
  output logic      [7:0] addr_o,
  output logic            wr_o,
  output logic            rd_o,
  output logic      [7:0] wdata_o,
  output logic            xfer_o,
  input  wire logic [7:0] rdata_i
);
  logic busy = 1'b0;
  logic hold = 1'b0;
  // Transfer spans each byte, longer while the bench holds it
  assign xfer_o = busy | hold;
  initial begin
    addr_o = 8'h00;
    wdata_o = 8'h00;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end
  // Byte write; a clear goes out as ones at its positions
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_i);
    busy = 1'b1;
    addr_o = a;
    wdata_o = d;
    wr_o = 1'b1;
    @(negedge clk_i);
    wr_o = 1'b0;
    busy = 1'b0;
    addr_o = ~a; // Released lines show junk, not old values
    wdata_o = ~d;
  endtask
  // Byte read; data taken one cycle after the strobe edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_i);
    busy = 1'b1;
    addr_o = a;
    rd_o = 1'b1;
    @(negedge clk_i);
    d = rdata_i;
    rd_o = 1'b0;
    busy = 1'b0;
    addr_o = ~a;
  endtask
endmodule
`default_nettype wire

// *** sim/acsr_regs_tb.sv ***
// Self-checking bench for the status and output register bank.
// Assumes the host model; assertions live inside the design.
`timescale 1ns/1ns
`default_nettype none
module acsr_regs_tb import acsr_pkg::*; ;
  logic        sys_clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  addr, wdata, rdata, tv, st;
  logic        wr, rd, xfer, irq, oe_n, srst;
  logic        meas = 1'b0;
  logic        otp = 1'b0;
  logic [3:0]  shk = 4'h0;
  logic [1:0]  orientation_debounce_count = 2'h0;
  logic [11:0] xv = 12'h000;
  logic [11:0] yv = 12'h000;
  logic [11:0] zv = 12'h000;
  logic [11:0] x, y, z;
  int          n_errors = 0;
  int          num_checks = 0;
  // Rows: x, y, z, temperature, expected instant status
  logic [51:0] rows [8] = '{
    52'h400_000_000_00_10, 52'hc00_000_000_7f_12,
    52'h000_400_000_80_11, 52'h000_c00_000_01_13,
    52'h180_000_400_ff_1b, 52'he80_000_c00_5a_1f,
    52'h181_000_000_a5_10, 52'h7ff_800_000_3c_13
  };
  always #10 sys_clk = ~sys_clk;
  acsr_host_model host (.clk_i(sys_clk), .addr_o(addr), .wr_o(wr), .rd_o(rd),
    .wdata_o(wdata), .xfer_o(xfer), .rdata_i(rdata));
  acsr_regs dut (.sys_clk_i(sys_clk), .rst_i(rst), .reg_addr_i(addr), .reg_wr_i(wr),
    .reg_rd_i(rd), .reg_wdata_i(wdata), .xfer_active_i(xfer), .reg_rdata_o(rdata),
    .meas_valid_i(meas), .x_accel_i(xv), .y_accel_i(yv), .z_accel_i(zv),
    .temperature_value_i(tv), .otp_done_i(otp), .shake_evt_i(shk),
    .orientation_debounce_count_i(orientation_debounce_count), .irq_pin_o(irq), .irq_pin_oe_n_o(oe_n),
    .soft_reset_o(srst));
  // Compare and count
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] v;
    host.rd(a, v);
    chk(v, exp);
  endtask
  // One sample pulse on the measurement path
  task automatic sample(input logic [11:0] a, b, c, input logic [7:0] t);
    @(negedge sys_clk);
    xv = a;
    yv = b;
    zv = c;
    tv = t;
    meas = 1'b1;
    @(negedge sys_clk);
    meas = 1'b0;
  endtask
  // Count-1 equal readings must not move the field, the next must
  task automatic settle(input logic [1:0] c, input logic [11:0] b, input logic [1:0] o, n);
    int k;
    orientation_debounce_count = c;
    for (k = 1; k < (16 << c); k++)
      sample(12'h000, b, 12'h000, 8'h00);
    rdc(OFS_SRC1, {2'b00, o, 4'h1});
    sample(12'h000, b, 12'h000, 8'h00);
    rdc(OFS_SRC1, {2'b00, n, 4'h1});
  endtask
  task automatic irq_is(input logic e);
    @(negedge sys_clk);
    chk({7'h00, oe_n}, {7'h00, e});
  endtask
  task automatic final_report;
    $display("errors %0d checks %0d", n_errors, num_checks);
    if (n_errors == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // Watchdog, far beyond the eight hundred or so cycles the run needs
  initial begin
    #1000000;
    n_errors++;
    final_report;
  end
  initial begin
    tv = 8'h00;
    repeat (10) @(negedge sys_clk);
    rst = 1'b0;
    chk({6'h00, oe_n, irq}, 8'h02);
    chk({7'h00, srst}, 8'h00);
    rdc(OFS_SRC1, 8'h00);
    rdc(OFS_STATUS, 8'h00);
    // Calibration load pulse; samples are published with or without it
    otp = 1'b1;
    @(negedge sys_clk);
    otp = 1'b0;
    rdc(OFS_SRC1, 8'h00);
    foreach (rows[i]) begin
      {x, y, z, tv, st} = rows[i];
      sample(x, y, z, tv);
      rdc(OFS_X_HI, x[11:4]);
      rdc(OFS_X_LO, {x[3:0], 4'h0});
      rdc(OFS_Y_HI, y[11:4]);
      rdc(OFS_Y_LO, {y[3:0], 4'h0});
      rdc(OFS_Z_HI, z[11:4]);
      rdc(OFS_Z_LO, {z[3:0], 4'h0});
      rdc(OFS_TEMP, tv);
      rdc(OFS_STATUS, st);
      rdc(OFS_SRC1, 8'h01);
    end
    settle(2'h0, 12'h400, 2'h0, 2'h1);
    settle(2'h1, 12'hc00, 2'h1, 2'h3);
    settle(2'h2, 12'h400, 2'h3, 2'h1);
    settle(2'h3, 12'hc00, 2'h1, 2'h3);
    // Heavy tilt: Z field goes up-tilted, plane field keeps its last value
    orientation_debounce_count = 2'h0;
    sample(12'h000, 12'h400, 12'h000, 8'h00);
    for (int k = 0; k < 16; k++)
      sample(12'h000, 12'h000, 12'h400, 8'h00);
    rdc(OFS_SRC1, 8'hb1);
    // Shake sources, partial clear, then each mask in turn
    shk = 4'hf;
    @(negedge sys_clk);
    shk = 4'h0;
    rdc(OFS_SRC0, 8'hcf);
    host.wr(OFS_SRC0, 8'h05);
    rdc(OFS_SRC0, 8'hca);
    host.wr(OFS_MASK0, 8'h02);
    irq_is(1'b0);
    host.wr(OFS_MASK0, 8'h04);
    irq_is(1'b1);
    host.wr(OFS_MASK0, 8'h40);
    irq_is(1'b0);
    host.wr(OFS_MASK0, 8'h00);
    host.wr(OFS_MASK1, 8'h01);
    irq_is(1'b0);
    host.wr(OFS_SRC1, 8'h01);
    irq_is(1'b1);
    rdc(OFS_MASK0, 8'h00);
    rdc(8'h0c, 8'h00);
    // Read-only places ignore writes; calibration flag sticks
    host.wr(OFS_STATUS, 8'h00);
    rdc(OFS_STATUS, 8'h19);
    host.wr(OFS_X_HI, 8'h55);
    rdc(OFS_X_HI, 8'h00);
    // A sample landing mid-transfer is published whole afterwards
    host.hold = 1'b1;
    sample(12'h123, 12'h456, 12'h789, 8'h11);
    rdc(OFS_X_HI, 8'h00);
    host.hold = 1'b0;
    rdc(OFS_X_HI, 8'h12);
    rdc(OFS_Z_LO, 8'h90);
    // Soft reset lasts as long as its transfer
    host.hold = 1'b1;
    host.wr(OFS_SRC1, 8'h80);
    repeat (3) @(negedge sys_clk);
    chk({7'h00, srst}, 8'h01);
    rdc(OFS_X_HI, 8'h00);
    host.hold = 1'b0;
    repeat (3) @(negedge sys_clk);
    chk({7'h00, srst}, 8'h00);
    rdc(OFS_STATUS, 8'h00);
    rdc(OFS_Z_LO, 8'h00);
    final_report;
  end
endmodule
`default_nettype wire
